// [hw/rsa_i2c_slave.sv]
// Functional notes
// - Respond only to START plus own address
// - Sixty-four byte space, sequential access order
// - Power fail aborts, clears pointer, ignores bus
// - Protection holds for recovery delay after return
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Data stable while SCL high, one bit/pulse
// - Eight-bit bytes plus ninth acknowledge bit
// - No limit on bytes per transfer
// - Acknowledge low through whole ack high phase
// - Master nack ends read, device releases SDA
// - Ack address, word address, every data byte
// - Write direction loads word address into pointer
// - Write at pointer, advance on ack clock
// - Read pointer advances only on master ack
// - Keep sending consecutive bytes while master acks
// - Freeze clock updates while pointer reads clock
// - Read without address uses current pointer
`timescale 1ns/10ps
module rsa_i2c_slave #(
    parameter int RECOVERY_CYCLES = rsa_pkg::RECOVERY_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Supply monitor, high while below the power fail threshold
    input wire logic below_power_fail_threshold,
    // Byte store, read data valid one cycle after mem_addr
    output logic [rsa_pkg::PTR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    input wire logic [7:0] mem_rdata,
    // Status to clock and supervisor logic
    output logic clock_hold,
    output logic write_protect
);
    localparam int CNT_W = $clog2(RECOVERY_CYCLES + 1);
    logic [2:0] pin_s, pin_p;
    logic scl_s, sda_s, scl_p, sda_p, pf_s;
    logic scl_rise, scl_fall, start_det, stop_det;

    default clocking cb_chk @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    rsa_pin_sync #(.WIDTH(3), .IDLE_VAL(rsa_pkg::PIN_IDLE)) u_sync (
        .clk(clk), .sys_rst(sys_rst),
        .async_i({below_power_fail_threshold, sda_i, scl_i}),
        .sync_o(pin_s), .prev_o(pin_p)
    );
    assign scl_s = pin_s[rsa_pkg::LANE_SCL];
    assign sda_s = pin_s[rsa_pkg::LANE_SDA];
    assign pf_s = pin_s[rsa_pkg::LANE_PF];
    assign scl_p = pin_p[rsa_pkg::LANE_SCL];
    assign sda_p = pin_p[rsa_pkg::LANE_SDA];
    // sample on rise, drive on fall
    assign scl_rise = scl_s && !scl_p;
    assign scl_fall = !scl_s && scl_p;
    assign start_det = scl_s && scl_p && sda_p && !sda_s;
    assign stop_det = scl_s && scl_p && !sda_p && sda_s;
    // Protection group
    logic prot_q, prot_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    always_comb begin
        prot_d = 1'b0;
        cnt_d = cnt_q;
        if (pf_s) begin
            prot_d = 1'b1;
            cnt_d = CNT_W'(RECOVERY_CYCLES);
        end else if (cnt_q != '0) begin
            prot_d = 1'b1;
            cnt_d = cnt_q - 1'b1;
        end
    end
    // Reset counts as a fresh power-up, so protection starts active
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prot_q <= 1'b1;
            cnt_q <= CNT_W'(RECOVERY_CYCLES);
        end else begin
            prot_q <= prot_d;
            cnt_q <= cnt_d;
        end
    end
    // Protocol group
    rsa_pkg::rsa_state_t state_q, state_d;
    rsa_pkg::rsa_kind_t kind_q, kind_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shreg_q, shreg_d;
    logic [rsa_pkg::PTR_W-1:0] ptr_q, ptr_d;
    logic rw_q, rw_d, rd_q, rd_d, oe_q, oe_d, we_q, we_d, hold_q, hold_d;
    logic [7:0] wdata_q, wdata_d;

    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        bit_cnt_d = bit_cnt_q;
        shreg_d = shreg_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        rd_d = rd_q;
        oe_d = oe_q;
        we_d = 1'b0;
        wdata_d = wdata_q;
        if (pf_s) begin
            state_d = rsa_pkg::ST_IDLE;
            oe_d = 1'b0;
            rd_d = 1'b0;
            ptr_d = rsa_pkg::PTR_RESET;
        end else if (prot_q) begin
            state_d = rsa_pkg::ST_IDLE;
            oe_d = 1'b0;
            rd_d = 1'b0;
        end else if (start_det) begin
            state_d = rsa_pkg::ST_RX;
            kind_d = rsa_pkg::K_SADDR;
            bit_cnt_d = rsa_pkg::BIT_FIRST;
            oe_d = 1'b0;
            rd_d = 1'b0;
        end else if (stop_det) begin
            state_d = rsa_pkg::ST_IDLE;
            oe_d = 1'b0;
            rd_d = 1'b0;
        end else begin
            unique case (state_q)
                rsa_pkg::ST_IDLE: begin
                end
                rsa_pkg::ST_RX: begin
                    if (scl_rise && bit_cnt_q != rsa_pkg::BIT_LAST) begin
                        shreg_d = {shreg_q[6:0], sda_s};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == rsa_pkg::BIT_LAST) begin
                        bit_cnt_d = rsa_pkg::BIT_FIRST;
                        state_d = rsa_pkg::ST_ACK;
                        oe_d = 1'b1;
                        unique case (kind_q)
                            rsa_pkg::K_SADDR: begin
                                if (shreg_q[7:1] == rsa_pkg::SLAVE_ADDR[7:1]) begin
                                    rw_d = shreg_q[0];
                                end else begin
                                    state_d = rsa_pkg::ST_IDLE;
                                    oe_d = 1'b0;
                                end
                            end
                            rsa_pkg::K_WADDR: begin
                                ptr_d = shreg_q[rsa_pkg::PTR_W-1:0];
                            end
                            rsa_pkg::K_DATA: begin
                                we_d = 1'b1;
                                wdata_d = shreg_q;
                            end
                        endcase
                    end
                end
                rsa_pkg::ST_ACK: begin
                    // held low until the ack clock falls
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        state_d = rsa_pkg::ST_RX;
                        if (kind_q == rsa_pkg::K_SADDR && rw_q) begin
                            shreg_d = mem_rdata;
                            state_d = rsa_pkg::ST_TX;
                            oe_d = !mem_rdata[7];
                            rd_d = 1'b1;
                        end else if (kind_q == rsa_pkg::K_SADDR) begin
                            kind_d = rsa_pkg::K_WADDR;
                        end else if (kind_q == rsa_pkg::K_WADDR) begin
                            kind_d = rsa_pkg::K_DATA;
                        end else begin
                            ptr_d = ptr_q + 1'b1;
                        end
                    end
                end
                rsa_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == rsa_pkg::TX_LAST) begin
                            state_d = rsa_pkg::ST_MACK;
                            bit_cnt_d = rsa_pkg::BIT_FIRST;
                            oe_d = 1'b0;
                        end else begin
                            shreg_d = {shreg_q[6:0], 1'b0};
                            bit_cnt_d = bit_cnt_q + 4'h1;
                            oe_d = !shreg_q[6];
                        end
                    end
                end
                rsa_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        if (!sda_s) begin
                            ptr_d = ptr_q + 1'b1;
                            bit_cnt_d = rsa_pkg::ACKED;
                        end else begin
                            state_d = rsa_pkg::ST_IDLE;
                        end
                    end else if (scl_fall && bit_cnt_q == rsa_pkg::ACKED) begin
                        shreg_d = mem_rdata;
                        state_d = rsa_pkg::ST_TX;
                        bit_cnt_d = rsa_pkg::BIT_FIRST;
                        oe_d = !mem_rdata[7];
                    end
                end
            endcase
        end
        hold_d = rd_q && (ptr_q <= rsa_pkg::CLOCK_LAST);
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= rsa_pkg::ST_IDLE;
            kind_q <= rsa_pkg::K_SADDR;
            bit_cnt_q <= rsa_pkg::BIT_FIRST;
            shreg_q <= 8'h00;
            ptr_q <= rsa_pkg::PTR_RESET;
            rw_q <= 1'b0;
            rd_q <= 1'b0;
            oe_q <= 1'b0;
            we_q <= 1'b0;
            wdata_q <= 8'h00;
            hold_q <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            bit_cnt_q <= bit_cnt_d;
            shreg_q <= shreg_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            rd_q <= rd_d;
            oe_q <= oe_d;
            we_q <= we_d;
            wdata_q <= wdata_d;
            hold_q <= hold_d;
        end
    end

    // Open drain: level is always low, only the enable moves
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign mem_addr = ptr_q;
    assign mem_wdata = wdata_q;
    assign mem_we = we_q;
    assign clock_hold = hold_q;
    assign write_protect = prot_q;

    property p_start_restart;
        (start_det && !pf_s && !prot_q) |=> (state_q == rsa_pkg::ST_RX && bit_cnt_q == 4'h0
            && ptr_q == $past(ptr_q));
    endproperty
    a_start_restart: assert property (p_start_restart)
        else $error("start did not restart reception");
    property p_stop_release;
        (stop_det && !start_det) |=> (state_q == rsa_pkg::ST_IDLE && !sda_oe ##1 !clock_hold);
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("stop did not end the transfer");
    property p_power_fail_abort;
        pf_s |=> (ptr_q == 6'h00 && !sda_oe && !mem_we && write_protect);
    endproperty
    a_power_fail_abort: assert property (p_power_fail_abort)
        else $error("power fail did not abort access");
    property p_protect_blocks;
        prot_q |=> (state_q == rsa_pkg::ST_IDLE && !mem_we);
    endproperty
    a_protect_blocks: assert property (p_protect_blocks)
        else $error("bus served while protected");
    property p_read_advance;
        (state_q == rsa_pkg::ST_MACK && scl_rise && !sda_s && !pf_s && !prot_q
            && !start_det && !stop_det) |=> (ptr_q == 6'($past(ptr_q) + 6'h01));
    endproperty
    a_read_advance: assert property (p_read_advance)
        else $error("pointer not advanced on master ack");
    property p_wrap;
        (ptr_q == 6'h3f && state_q == rsa_pkg::ST_MACK && scl_rise && !sda_s && !pf_s
            && !prot_q && !start_det && !stop_det) |=> (ptr_q == 6'h00);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("pointer did not wrap to zero");
    property p_clock_hold;
        (rd_q && ptr_q <= 6'h07) |=> clock_hold;
    endproperty
    a_clock_hold: assert property (p_clock_hold)
        else $error("clock updates not held during read");
    property p_ack_held;
        (state_q == rsa_pkg::ST_ACK && scl_s) |-> sda_oe;
    endproperty
    a_ack_held: assert property (p_ack_held)
        else $error("acknowledge not low during clock high");
    property p_stable_high;
        (scl_s && $past(scl_s) && !pf_s && !$past(prot_q)) |-> $stable(sda_oe);
    endproperty
    a_stable_high: assert property (p_stable_high)
        else $error("sda changed while scl high");
    property p_write_ack;
        (state_q == rsa_pkg::ST_RX && kind_q == rsa_pkg::K_DATA && scl_fall
            && bit_cnt_q == 4'h8 && !pf_s && !prot_q && !start_det && !stop_det)
            |=> (mem_we && sda_oe && mem_addr == $past(ptr_q) ##1 !mem_we);
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("data byte not written and acknowledged");
    property p_mismatch;
        (state_q == rsa_pkg::ST_RX && kind_q == rsa_pkg::K_SADDR && scl_fall
            && bit_cnt_q == 4'h8 && shreg_q[7:1] != 7'h68 && !pf_s && !prot_q
            && !start_det && !stop_det) |=> (!sda_oe && state_q == rsa_pkg::ST_IDLE);
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("foreign address acknowledged");

endmodule

// [hw/rsa_pkg.sv]
package rsa_pkg;

    // Fixed slave address byte, direction bit in bit 0
    localparam logic [7:0] SLAVE_ADDR = 8'hd0;
    localparam int SPACE_BYTES = 64;
    localparam int PTR_W = 6;
    localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
    // Last clock location that freezes updates while read
    localparam logic [PTR_W-1:0] CLOCK_LAST = 6'h07;

    // Bit counter marks
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] TX_LAST = 4'h7;
    localparam logic [3:0] ACKED = 4'h1;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RECOVERY_DELAY_US = 200;
    // Least time, so rounded up
    localparam int RECOVERY_CYCLES =
        (RECOVERY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Synchroniser lanes and idle levels
    localparam int LANE_SCL = 0;
    localparam int LANE_SDA = 1;
    localparam int LANE_PF = 2;
    localparam logic [2:0] PIN_IDLE = 3'h3;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX = 5'b00010,
        ST_ACK = 5'b00100,
        ST_TX = 5'b01000,
        ST_MACK = 5'b10000
    } rsa_state_t;

    typedef enum logic [2:0] {
        K_SADDR = 3'b001,
        K_WADDR = 3'b010,
        K_DATA = 3'b100
    } rsa_kind_t;

endpackage

// [hw/rsa_pin_sync.sv]
`timescale 1ns/10ps
module rsa_pin_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] IDLE_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Asynchronous pins
    input wire logic [WIDTH-1:0] async_i,
    // Synchronised level and its previous sample
    output logic [WIDTH-1:0] sync_o,
    output logic [WIDTH-1:0] prev_o
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second, edges use stages two and three
    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                meta_q[i] <= IDLE_VAL[i];
                sync_o[i] <= IDLE_VAL[i];
                prev_o[i] <= IDLE_VAL[i];
            end else begin
                meta_q[i] <= async_i[i];
                sync_o[i] <= meta_q[i];
                prev_o[i] <= sync_o[i];
            end
        end
    end

endmodule

// [verification/rsa_bus_master.sv]
`timescale 1ns/10ps
module rsa_bus_master #(
    parameter int HALF = 10
) (
    // Clock
    input wire logic clk,
    // Bus wires, master pulls data low only
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic half();
        repeat (HALF) @(negedge clk);
    endtask

    task automatic start();
        repeat (2) @(negedge clk);
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask

    task automatic stop();
        repeat (2) @(negedge clk);
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask

    task automatic bit_io(input logic b, output logic s);
        repeat (2) @(negedge clk);
        sda_low = ~b;
        half();
        scl = 1'b1;
        half();
        s = sda;
        scl = 1'b0;
    endtask

    // Byte plus ninth bit, msb first
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Ack low, or withhold after last byte
    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~ack, s);
    endtask
endmodule

// [verification/tb_rsa_i2c_slave.sv]
`timescale 1ns/10ps
module tb_rsa_i2c_slave;
    localparam int RC = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pf = 1'b0;
    logic scl, sda_low, sda, sda_o, sda_oe, mem_we, clock_hold, write_protect;
    logic [5:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata;
    logic [7:0] mem [64];
    logic [7:0] exp_mem [64];
    logic [5:0] ptr = 6'h00;
    int n_fail = 0;
    int samples_checked = 0;
    int n_we = 0;
    int we_mark;
    logic ack;
    logic [7:0] d;
    logic [5:0] a;

    always #5 clk = ~clk;
    // Pull-up, low while either party pulls
    assign sda = ~((sda_oe & ~sda_o) | sda_low);
    // Byte store with asynchronous read
    assign mem_rdata = mem[mem_addr];
    always @(posedge clk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
            n_we <= n_we + 1;
        end
    end

    rsa_i2c_slave #(.RECOVERY_CYCLES(RC)) dut (
        .clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .below_power_fail_threshold(pf), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
        .clock_hold(clock_hold), .write_protect(write_protect)
    );
    rsa_bus_master #(.HALF(10)) bm (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Address phase of a write, leaves pointer at wa
    task automatic addr_wr(input logic [5:0] wa);
        bm.start();
        bm.send(8'hd0, ack);
        check(8'(ack), 8'h01, "slave ack");
        bm.send({2'b00, wa}, ack);
        check(8'(ack), 8'h01, "word ack");
        ptr = wa;
    endtask

    task automatic wr(input logic [5:0] wa, input int n);
        addr_wr(wa);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            bm.send(d, ack);
            check(8'(ack), 8'h01, "data ack");
            exp_mem[ptr] = d;
            ptr++;
            repeat (6) @(negedge clk);
            check(8'(mem_addr), 8'(ptr), "write ptr");
        end
        bm.stop();
    endtask

    task automatic rd(input logic addressed, input logic [5:0] ra, input int n);
        if (addressed) begin
            addr_wr(ra);
        end
        bm.start();
        bm.send(8'hd1, ack);
        check(8'(ack), 8'h01, "read ack");
        for (int i = 0; i < n; i++) begin
            bm.recv(i < n - 1, d);
            check(d, exp_mem[ptr], "read data");
            if (i < n - 1) begin
                ptr++;
            end
            check(8'(mem_addr), 8'(ptr), "read ptr");
            check(8'(clock_hold), 8'(ptr <= 6'h07), "hold");
        end
        bm.half();
        check(8'(sda), 8'h01, "released");
        bm.stop();
        repeat (4) @(negedge clk);
        check(8'(clock_hold), 8'h00, "hold after stop");
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        void'($urandom(83));
        for (int i = 0; i < 64; i++) begin
            exp_mem[i] = 8'($urandom);
            mem[i] = exp_mem[i];
        end
        repeat (10) @(negedge clk);
        check(8'(write_protect), 8'h01, "reset protect");
        check(8'(sda_oe), 8'h00, "reset release");
        sys_rst = 1'b0;
        repeat (RC + 10) @(negedge clk);
        check(8'(write_protect), 8'h00, "protect off");
        // Long transfer across the wrap
        wr(6'h3c, 40);
        rd(1'b1, 6'h3c, 40);
        // Clock locations hold updates
        rd(1'b1, 6'h05, 5);
        rd(1'b0, 6'h00, 2);
        for (int k = 0; k < 4; k++) begin
            a = 6'($urandom);
            wr(a, 1 + $urandom % 4);
            rd(1'b1, a, 3);
        end
        // Foreign address is ignored
        we_mark = n_we;
        bm.start();
        bm.send(8'ha0, ack);
        check(8'(ack), 8'h00, "foreign nack");
        bm.send(8'hd0, ack);
        check(8'(ack), 8'h00, "no ack in idle");
        bm.stop();
        // Repeated start mid-byte keeps pointer
        addr_wr(6'h0a);
        bm.bit_io(1'b0, ack);
        bm.bit_io(1'b1, ack);
        rd(1'b0, 6'h0a, 2);
        check(8'(n_we), 8'(we_mark), "no stray write");
        // Power fail mid write
        wr(6'h14, 0);
        addr_wr(6'h14);
        bm.send(8'h5a, ack);
        exp_mem[6'h14] = 8'h5a;
        repeat (6) @(negedge clk);
        we_mark = n_we;
        pf = 1'b1;
        repeat (8) @(negedge clk);
        check(8'(mem_addr), 8'h00, "pf pointer");
        check(8'(write_protect), 8'h01, "pf protect");
        check(8'(sda_oe), 8'h00, "pf release");
        bm.send(8'ha5, ack);
        check(8'(ack), 8'h00, "pf ignore");
        bm.stop();
        check(8'(n_we), 8'(we_mark), "pf no write");
        pf = 1'b0;
        repeat (RC) @(negedge clk);
        check(8'(write_protect), 8'h01, "recovery");
        repeat (10) @(negedge clk);
        check(8'(write_protect), 8'h00, "recovered");
        ptr = 6'h00;
        rd(1'b0, 6'h00, 1);
        for (int i = 0; i < 64; i++) begin
            check(mem[i], exp_mem[i], "store");
        end
        end_sim();
    end
endmodule
